// File: logic/smbtm_core.sv
// Purpose: two-wire transfer mode sequencing, master and slave
// Assumes: avalon slave on clk; bus wires open drain with pull-ups
// Notes: bit clock generated as master, stretched as slave
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "smbtm_map.svh"
module smbtm_core
  import smbtm_pkg::*;
#(
  parameter int HalfCycles = `SMBTM_HALF_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  smbtm_state_t s;
  smbtm_state_t next_s;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic wrAcc;
  logic wrCtl;
  logic wrDat;
  logic wrCfg;
  logic siClr;
  logic doAdv;
  logic tick;
  logic halfDone;
  logic [7:0] ctlVal;

  smbtm_sync #(
    .W(2)
  )
  uSync (
    .clk(clk),
    .arst_n(arst_n),
    .din({sclIn, sdaIn}),
    .dout({sclS, sdaS})
  );

  smbtm_cond uCond (
    .clk(clk),
    .arst_n(arst_n),
    .scl(sclS),
    .sda(sdaS),
    .rise(sclRise),
    .fall(sclFall),
    .start(startDet),
    .stop(stopDet)
  );

  assign ctlVal = {s.master, s.transmit_mode_flag, s.start_request_bit, s.stop_request_bit,
                   s.ack_request_flag, s.arbitration_lost_flag, s.ack, s.si}; // see RULE_18
  // a write lands at the edge where waitrequest is seen low
  assign wrAcc = write & ~s.waitReq & byteenable[0];
  assign wrCtl = wrAcc & (address == `SMBTM_CTL_OFS);
  assign wrDat = wrAcc & (address == `SMBTM_DAT_OFS);
  assign wrCfg = wrAcc & (address == `SMBTM_CFG_OFS);
  assign siClr = wrCtl & ~writedata[`SMBTM_SI_BIT] & s.si;
  // the high half waits for the wire, so a slave may stretch it
  assign tick = (s.step != 2'h1) | sclS;
  assign halfDone = tick & (s.cnt == 8'(HalfCycles - 1));

  always_comb
  begin
    next_s = s;
    doAdv = 1'b0;
    next_s.waitReq = ~((read | write) & s.waitReq);
    if (read & s.waitReq)
    begin
      case (address)
        `SMBTM_CTL_OFS: next_s.rdata = {24'h0, ctlVal};
        `SMBTM_DAT_OFS: next_s.rdata = {24'h0, s.shift};
        `SMBTM_CFG_OFS: next_s.rdata = {24'h0, s.ownAddr, s.slave_inhibit_bit};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (wrCtl)
    begin
      next_s.start_request_bit = writedata[`SMBTM_STA_BIT];
      next_s.stop_request_bit = writedata[`SMBTM_STO_BIT];
      next_s.ack = writedata[`SMBTM_ACK_BIT];
      if (siClr)
      begin
        next_s.si = 1'b0;
        next_s.ack_request_flag = 1'b0;
        next_s.pendSta = writedata[`SMBTM_STA_BIT]; // see RULE_24
        next_s.pendSto = writedata[`SMBTM_STO_BIT];
      end
    end
    if (wrCfg)
    begin
      next_s.slave_inhibit_bit = writedata[`SMBTM_INH_BIT];
      next_s.ownAddr = writedata[7:1];
    end
    // writes outside an interrupt would corrupt the shifting byte
    if (wrDat & s.si)
    begin
      next_s.shift = writedata[7:0];
      next_s.wrote = 1'b1;
      if (~s.master & s.transmit_mode_flag & ~s.ack & ~s.isAddr)
        next_s.arbitration_lost_flag = 1'b1; // see RULE_16
    end

    case (s.state)
      ST_IDLE:
      begin
        next_s.sclOe = 1'b0;
        next_s.sdaOe = 1'b0;
        if (s.start_request_bit & ~s.busy)
        begin
          next_s.state = ST_GEN;
          next_s.step = 2'h2;
          next_s.cnt = 8'h00;
          next_s.sdaOe = 1'b1; // see RULE_01
          next_s.master = 1'b1; // see RULE_22
          next_s.ignore = 1'b0;
          // a stale slave error must not show in master status
          next_s.arbitration_lost_flag = 1'b0;
        end
      end
      ST_GEN:
      begin
        if (!tick)
          next_s.cnt = 8'h00;
        else if (!halfDone)
          next_s.cnt = s.cnt + 8'h01;
        else
        begin
          next_s.cnt = 8'h00;
          next_s.step = s.step + 2'h1;
          case (s.step)
            2'h0: next_s.sclOe = 1'b0;
            2'h1:
            begin
              next_s.sdaOe = 1'b1;
              next_s.master = 1'b1; // see RULE_22
            end
            default:
            begin
              // start is out: hold the clock low and report it
              next_s.sclOe = 1'b1;
              next_s.state = ST_HOLD;
              next_s.si = 1'b1; // see RULE_19
              next_s.transmit_mode_flag = 1'b1;
              next_s.ack_request_flag = 1'b0;
              next_s.isAddr = 1'b0;
              next_s.bitCnt = 4'h9;
            end
          endcase
        end
      end
      ST_STOP:
      begin
        if (!tick)
          next_s.cnt = 8'h00;
        else if (!halfDone)
          next_s.cnt = s.cnt + 8'h01;
        else
        begin
          next_s.cnt = 8'h00;
          next_s.step = s.step + 2'h1;
          case (s.step)
            2'h0: next_s.sclOe = 1'b0;
            2'h1: next_s.sdaOe = 1'b0; // see RULE_03
            default:
            begin
              next_s.state = ST_IDLE;
              next_s.master = 1'b0; // see RULE_22
              next_s.stop_request_bit = 1'b0;
              next_s.transmit_mode_flag = 1'b0;
            end
          endcase
        end
      end
      ST_HOLD:
      begin
        next_s.sclOe = 1'b1; // see RULE_24
        if (siClr)
        begin
          if (s.bitCnt == 4'h8)
          begin
            if (s.isAddr & ~next_s.ack)
            begin
              next_s.ignore = 1'b1; // see RULE_10
              next_s.state = ST_IDLE;
              next_s.sclOe = 1'b0;
            end
            else
            begin
              next_s.state = ST_XFER;
              next_s.sdaOe = next_s.ack; // see RULE_06
              next_s.sclOe = s.master;
              next_s.cnt = 8'h00;
            end
          end
          else
            doAdv = 1'b1; // see RULE_20
        end
      end
      ST_XFER:
      begin
        if (s.master)
        begin
          if (s.sclOe | sclS)
            next_s.cnt = s.cnt + 8'h01;
          if ((s.sclOe | sclS) & (s.cnt == 8'(HalfCycles - 1)))
          begin
            next_s.cnt = 8'h00;
            next_s.sclOe = ~s.sclOe;
          end
        end
        if (sclRise)
        begin
          next_s.bitCnt = s.bitCnt + 4'h1;
          if (s.bitCnt < 4'h8)
            next_s.shift = {s.shift[6:0], sdaS}; // see RULE_02
          else if (s.transmit_mode_flag)
            next_s.ack = ~sdaS;
        end
        if (sclFall)
        begin
          if (s.bitCnt == 4'h8)
          begin
            next_s.sdaOe = 1'b0;
            if (s.isAddr)
            begin
              if ((s.shift[7:1] == s.ownAddr) & ~s.slave_inhibit_bit & ~s.ignore)
              begin
                next_s.state = ST_HOLD; // see RULE_09
                next_s.sclOe = 1'b1;
                next_s.si = 1'b1;
                next_s.ack_request_flag = 1'b1;
                next_s.transmit_mode_flag = 1'b0; // see RULE_14
              end
              else
                next_s.state = ST_IDLE;
            end
            else if (!s.transmit_mode_flag)
            begin
              // receiver interrupts before the ack bit
              next_s.state = ST_HOLD; // see RULE_23
              next_s.sclOe = 1'b1;
              next_s.si = 1'b1; // see RULE_05
              next_s.ack_request_flag = 1'b1; // see RULE_21
            end
          end
          else if (s.bitCnt == 4'h9)
          begin
            next_s.sdaOe = 1'b0;
            if (s.transmit_mode_flag)
            begin
              // transmitter interrupts after the ack bit
              next_s.state = ST_HOLD; // see RULE_23
              next_s.sclOe = 1'b1;
              next_s.si = 1'b1; // see RULE_20
            end
            else
              doAdv = 1'b1; // see RULE_21
          end
          else if (s.transmit_mode_flag)
            // after a refused byte the slave keeps off the wire until STOP
            next_s.sdaOe = ~s.shift[7] & ~s.arbitration_lost_flag; // see RULE_01
        end
      end
      default: next_s.state = ST_IDLE;
    endcase

    if (doAdv)
    begin
      next_s.cnt = 8'h00;
      next_s.step = 2'h0;
      if (s.master & next_s.pendSto)
      begin
        next_s.state = ST_STOP; // see RULE_03
        next_s.sdaOe = 1'b1;
        next_s.sclOe = 1'b1;
      end
      else if (s.master & next_s.pendSta)
      begin
        next_s.state = ST_GEN; // see RULE_20
        next_s.sdaOe = 1'b0;
        next_s.sclOe = 1'b1;
      end
      else
      begin
        next_s.state = ST_XFER;
        next_s.bitCnt = 4'h0;
        next_s.isAddr = 1'b0;
        // direction follows whether software loaded a byte
        next_s.transmit_mode_flag = s.wrote; // see RULE_04, RULE_08, RULE_13, RULE_17
        next_s.sdaOe = s.wrote & ~s.shift[7] & ~s.arbitration_lost_flag; // see RULE_16
        next_s.sclOe = s.master;
        next_s.wrote = 1'b0;
      end
    end

    if (startDet)
    begin
      next_s.busy = 1'b1;
      if (!s.master)
      begin
        next_s.state = ST_XFER;
        next_s.isAddr = 1'b1;
        next_s.bitCnt = 4'h0;
        next_s.ignore = 1'b0; // see RULE_10
        next_s.transmit_mode_flag = 1'b0;
        next_s.arbitration_lost_flag = 1'b0;
        next_s.sdaOe = 1'b0;
        next_s.sclOe = 1'b0;
      end
    end
    if (stopDet)
    begin
      next_s.busy = 1'b0;
      if (!s.master)
      begin
        next_s.state = ST_IDLE; // see RULE_12
        next_s.transmit_mode_flag = 1'b0;
        next_s.sdaOe = 1'b0;
        next_s.sclOe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.state <= ST_IDLE;
      s.slave_inhibit_bit <= `SMBTM_INH_RST;
      s.ownAddr <= `SMBTM_ADR_RST;
      s.ack <= `SMBTM_ACK_RST;
      s.waitReq <= 1'b1;
    end
    else
      s <= next_s;
  end

  // open drain: the wire is only ever pulled low
  assign sclOut = s.lineLvl;
  assign sdaOut = s.lineLvl;
  assign sclOe = s.sclOe;
  assign sdaOe = s.sdaOe;
  assign readdata = s.rdata;
  assign waitrequest = s.waitReq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence startOut;
    s.state == ST_GEN && s.step == 2'h2 && halfDone;
  endsequence

  sequence stopOut;
    s.state == ST_STOP && s.step == 2'h2 && halfDone;
  endsequence

  start_vector_a: assert property ( // see RULE_19
    startOut |=> s.si && s.master && s.transmit_mode_flag && !s.ack_request_flag && !s.arbitration_lost_flag)
    else $error("start not reported as master transmitter");

  stop_end_a: assert property ( // see RULE_03
    stopOut |=> s.state == ST_IDLE && !s.master && !s.stop_request_bit && !s.sdaOe
    && !s.transmit_mode_flag)
    else $error("stop did not end master operation");

  hold_clock_a: assert property ( // see RULE_24
    s.state == ST_HOLD && s.si && !siClr |=> s.sclOe [*1])
    else $error("clock released while interrupt pending");

  ack_drive_a: assert property ( // see RULE_06
    s.state == ST_HOLD && siClr && s.bitCnt == 4'h8 && !s.isAddr
    |=> s.sdaOe == s.ack && s.state == ST_XFER)
    else $error("outgoing acknowledge does not follow control bit");

  rx_flag_a: assert property ( // see RULE_05
    s.state == ST_XFER && sclFall && s.bitCnt == 4'h8 && !s.transmit_mode_flag
    && !s.isAddr && !startDet && !stopDet
    |=> s.si && s.ack_request_flag && s.state == ST_HOLD)
    else $error("receiver byte did not request acknowledge");

  tx_flag_a: assert property ( // see RULE_23
    s.state == ST_XFER && sclFall && s.bitCnt == 4'h9 && s.transmit_mode_flag
    && !startDet && !stopDet |=> s.si && !s.ack_request_flag)
    else $error("transmitter interrupt not after ack bit");

  tx_to_rx_a: assert property ( // see RULE_04
    s.state == ST_HOLD && siClr && s.bitCnt == 4'h9 && !s.wrote
    && !writedata[`SMBTM_STA_BIT] && !writedata[`SMBTM_STO_BIT]
    && !startDet && !stopDet |=> !s.transmit_mode_flag && s.state == ST_XFER)
    else $error("no data write did not select receive");

  rx_to_tx_a: assert property ( // see RULE_08
    s.state == ST_XFER && sclFall && s.bitCnt == 4'h9 && !s.transmit_mode_flag
    && s.wrote && !s.pendSta && !s.pendSto && !startDet && !stopDet
    |=> s.transmit_mode_flag ##1 s.bitCnt == 4'h0)
    else $error("data write did not select transmit");

  slave_stop_a: assert property ( // see RULE_12
    stopDet && !s.master |=> s.state == ST_IDLE && !s.transmit_mode_flag)
    else $error("slave mode kept after stop");

  ignore_mute_a: assert property ( // see RULE_10
    s.ignore && !s.si && !s.master && !$rose(startDet) |=> !s.si)
    else $error("slave interrupt while address ignored");
endmodule : smbtm_core

// File: logic/smbtm_map.svh
// Purpose: address map, bit positions, reset values and timing counts
// Assumes: included by the core only; the package does not include it
// Notes: offsets are byte addresses on the avalon slave
//
// Summary of operation
// RULE_01 - master transmitter: START, drive clock, address byte with write bit 0
// RULE_02 - master receiver: START, address byte with read bit 1, clock in bytes
// RULE_03 - master transfer ends only when stop request set, giving a STOP
// RULE_04 - master transmitter without data write after interrupt becomes receiver
// RULE_05 - master receiver: after each byte set ack request and interrupt
// RULE_06 - outgoing acknowledge follows control bit 1: 1 gives ACK, 0 NACK
// RULE_07 - software writes acknowledge 0 after last byte of a master read
// RULE_08 - active master receiver becomes transmitter when data register written
// RULE_09 - with inhibit 0, START plus own address and write enters slave receiver
// RULE_10 - slave address answered with NACK mutes slave interrupts until next START
// RULE_11 - slave receiver software writes acknowledge bit after every byte
// RULE_12 - slave receiver and slave transmitter are left on a STOP
// RULE_13 - active slave receiver becomes transmitter when data register written
// RULE_14 - read address is first received, interrupts with ack request, then transmits
// RULE_15 - slave transmitter software loads next byte before clearing interrupt
// RULE_16 - data write after NACK as slave transmitter raises an error flag
// RULE_17 - slave transmitter without data write after interrupt becomes receiver
// RULE_18 - status vector is control bits 7..4: master, transmit, start, stop
// RULE_19 - after master START report 1110 with ack request and lost flag 0
// RULE_20 - after master byte sent report 1100; clear acts on start and stop
// RULE_21 - after master byte received report 1000; ack then STOP or START
// RULE_22 - master from generated START until STOP or lost arbitration; code clears master only after its own STOP
// RULE_23 - interrupt before ack cycle when receiving, after it when transmitting
// RULE_24 - bus held at each interrupt until cleared, then acts on controls
`ifndef SMBTM_MAP_SVH
`define SMBTM_MAP_SVH
`define SMBTM_CTL_OFS 4'h0
`define SMBTM_DAT_OFS 4'h4
`define SMBTM_CFG_OFS 4'h8
`define SMBTM_SI_BIT 0
`define SMBTM_ACK_BIT 1
`define SMBTM_STO_BIT 4
`define SMBTM_STA_BIT 5
`define SMBTM_INH_BIT 0
`define SMBTM_INH_RST 1'b1
`define SMBTM_ADR_RST 7'h00
`define SMBTM_ACK_RST 1'b0
`define SMBTM_CLK_NS 100
`define SMBTM_SCL_NS 800
`define SMBTM_HALF_CYC (`SMBTM_SCL_NS / `SMBTM_CLK_NS / 2)
`endif

// File: logic/smbtm_pkg.sv
// Purpose: types shared by the transfer mode core
// Assumes: nothing beyond the map header
// Notes: state codes are one-hot
package smbtm_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GEN = 5'h02,
    ST_XFER = 5'h04,
    ST_HOLD = 5'h08,
    ST_STOP = 5'h10
  } smbtm_st_t;

  typedef struct packed {
    smbtm_st_t state;
    logic [1:0] step;
    logic [7:0] cnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic master;
    logic transmit_mode_flag;
    logic start_request_bit;
    logic stop_request_bit;
    logic ack_request_flag;
    logic arbitration_lost_flag;
    logic ack;
    logic si;
    logic slave_inhibit_bit;
    logic [6:0] ownAddr;
    logic isAddr;
    logic ignore;
    logic busy;
    logic wrote;
    logic pendSta;
    logic pendSto;
    logic sclOe;
    logic sdaOe;
    logic lineLvl;
    logic waitReq;
    logic [31:0] rdata;
  } smbtm_state_t;
endpackage : smbtm_pkg

// File: logic/smbtm_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs idle high like the bus wires
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module smbtm_sync #(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= {W{1'b1}};
      dout <= {W{1'b1}};
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : smbtm_sync

// File: logic/smbtm_cond.sv
// Purpose: clock edges and START / STOP detection on synchronised lines
// Assumes: scl and sda already synchronised to clk
// Notes: outputs are one-cycle pulses
`timescale 1ns/100ps
module smbtm_cond (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  output logic rise,
  output logic fall,
  output logic start,
  output logic stop
);
  logic [1:0] prev;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prev <= 2'h3;
    else
      prev <= {scl, sda};
  end

  assign rise = scl & ~prev[1];
  assign fall = ~scl & prev[1];
  // data moving while the clock stays high marks a condition
  assign start = scl & prev[1] & prev[0] & ~sda;
  assign stop = scl & prev[1] & ~prev[0] & sda;
endmodule : smbtm_cond

// File: test/smbtm_far_end.sv
// Purpose: far side of the wires: one slave plus master bit tasks
// Assumes: open-drain wires with pull-ups, wire levels fed back in
// Notes: its own bit clock runs only inside frames that it opens
`timescale 1ns/100ps
module smbtm_far_end #(
  parameter logic [6:0] SlvAddr = 7'h50,
  parameter int HalfNs = 400
)
(
  input wire logic scl,
  input wire logic sda,
  output logic sclOe,
  output logic sdaOe
);
  logic [7:0] rxLog [$];
  logic [7:0] txQ [$];
  logic ackLog [$];
  logic [7:0] sh;
  logic [7:0] rdByte;
  logic rd;
  logic mst = 1'b0;

  initial
  begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end

  task automatic ackSlot();
    @(negedge scl);
    sdaOe = 1'b1;
    @(negedge scl);
    sdaOe = 1'b0;
  endtask : ackSlot

  // slave frame; a STOP cuts it short wherever it stands
  initial
  begin
    forever
    begin : frame
      @(negedge sda iff (scl === 1'b1 && !mst));
      for (int i = 0; i < 8; i++)
        @(posedge scl) sh = {sh[6:0], sda};
      rd = sh[0];
      if (sh[7:1] != SlvAddr)
        forever @(posedge scl);
      ackSlot();
      forever
      begin
        if (rd)
        begin
          sh = txQ.pop_front();
          for (int i = 7; i >= 0; i--)
          begin
            sdaOe = !sh[i];
            @(negedge scl);
          end
          sdaOe = 1'b0;
          @(posedge scl) ackLog.push_back(sda);
          // a refused byte ends our turn: stay off the wire
          if (sda)
            forever @(posedge scl);
          @(negedge scl);
        end
        else
        begin
          for (int i = 0; i < 8; i++)
            @(posedge scl) sh = {sh[6:0], sda};
          rxLog.push_back(sh);
          ackSlot();
        end
      end
    end
  end

  always @(posedge sda)
  begin
    if (scl === 1'b1)
    begin
      sdaOe = 1'b0;
      disable frame;
    end
  end

  // high half waits for the wire: the other side may stretch
  task automatic mBit(input logic b, output logic r);
    sdaOe = !b;
    #(HalfNs);
    sclOe = 1'b0;
    wait (scl === 1'b1);
    r = sda;
    #(HalfNs);
    sclOe = 1'b1;
  endtask : mBit

  task automatic mByte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      mBit(b[i], r);
    mBit(1'b1, r);
    ackLog.push_back(r);
  endtask : mByte

  task automatic mStart(input logic [7:0] a);
    mst = 1'b1;
    sdaOe = 1'b1;
    #(HalfNs);
    sclOe = 1'b1;
    mByte(a);
  endtask : mStart

  task automatic mRead(input logic nack);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      mBit(1'b1, r);
      rdByte = {rdByte[6:0], r};
    end
    mBit(nack, r);
  endtask : mRead

  task automatic mStop();
    sdaOe = 1'b1;
    #(HalfNs);
    sclOe = 1'b0;
    wait (scl === 1'b1);
    #(HalfNs);
    sdaOe = 1'b0;
    #(HalfNs);
    mst = 1'b0;
  endtask : mStop
endmodule : smbtm_far_end

// File: test/smbus_transfer_mode_control_test.sv
// Purpose: register-level test of the transfer mode core
// Assumes: far-end model on the wires, pull-ups on both lines
// Notes: slave cases fork the far-end master beside the bus traffic
`timescale 1ns/100ps
module smbus_transfer_mode_control_test;
  logic clk, arst_n, read, write, waitrequest;
  logic sclOe, sdaOe, farScl, farSda, sclW, sdaW;
  logic sclLvl, sdaLvl;
  logic [3:0] be;
  logic [3:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0] v;
  int fails, checked, cycles;

  assign sclW = !(sclOe | farScl);
  assign sdaW = !(sdaOe | farSda);

  smbtm_core u_dut (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be),
    .readdata(readdata), .waitrequest(waitrequest), .sclIn(sclW),
    .sclOut(sclLvl), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaLvl),
    .sdaOe(sdaOe)
  );
  smbtm_far_end u_far (
    .scl(sclW), .sda(sdaW), .sclOe(farScl), .sdaOe(farSda)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      $display("MISMATCH %0t run too long", $time);
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at an edge
  task automatic acc(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h000000, d};
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    v = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    chk({7'h00, waitrequest}, 8'h00, "bus answer");
    @(posedge clk);
  endtask : acc

  task automatic rdChk(input logic [3:0] a, input logic [7:0] m,
                       input logic [7:0] e, input string what);
    acc(1'b0, a, 8'h00);
    chk(v & m, e, what);
  endtask : rdChk

  // polls control; bounded so a stuck flag still ends the wait
  task automatic waitCtl(input logic [7:0] m, input logic [7:0] e,
                         input string what);
    int n;
    n = 0;
    acc(1'b0, 4'h0, 8'h00);
    while ((v & m) !== e && n < 400)
    begin
      n++;
      acc(1'b0, 4'h0, 8'h00);
    end
    chk(v & m, e, what);
  endtask : waitCtl

  initial
  begin
    arst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    be = 4'h1;
    fails = 0;
    checked = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdChk(4'h0, 8'hff, 8'h00, "ctrl reset");
    rdChk(4'h8, 8'hff, 8'h01, "cfg reset");
    rdChk(4'hc, 8'hff, 8'h00, "unmapped");
    // lane 0 disabled: the write must be dropped
    be <= 4'h0;
    acc(1'b1, 4'h8, 8'hfe);
    be <= 4'h1;
    rdChk(4'h8, 8'hff, 8'h01, "lane off");
    // master write: address, one byte, stop
    acc(1'b1, 4'h0, 8'h20);
    waitCtl(8'hfd, 8'he1, "start vector");
    acc(1'b1, 4'h4, 8'ha0);
    acc(1'b1, 4'h0, 8'h00);
    waitCtl(8'hff, 8'hc3, "addr sent");
    acc(1'b1, 4'h4, 8'ha5);
    acc(1'b1, 4'h0, 8'h00);
    waitCtl(8'hff, 8'hc3, "data sent");
    acc(1'b1, 4'h0, 8'h10);
    waitCtl(8'hf0, 8'h00, "stop done");
    chk(u_far.rxLog[0], 8'ha5, "byte on wire");
    chk({6'h00, sclLvl, sdaLvl}, 8'h00, "line level");
    // master read of two bytes, last one refused
    u_far.txQ = {8'h3c, 8'hc3};
    acc(1'b1, 4'h0, 8'h20);
    waitCtl(8'h01, 8'h01, "restart");
    acc(1'b1, 4'h4, 8'ha1);
    acc(1'b1, 4'h0, 8'h00);
    waitCtl(8'hff, 8'hc3, "read addr");
    acc(1'b1, 4'h0, 8'h00);
    waitCtl(8'hfd, 8'h89, "rx vector");
    rdChk(4'h4, 8'hff, 8'h3c, "first byte");
    acc(1'b1, 4'h0, 8'h02);
    waitCtl(8'hfd, 8'h89, "rx vector 2");
    rdChk(4'h4, 8'hff, 8'hc3, "second byte");
    // last byte refused with a repeated START, then STOP
    acc(1'b1, 4'h0, 8'h20);
    waitCtl(8'hfd, 8'he1, "restart vector");
    acc(1'b1, 4'h0, 8'h10);
    waitCtl(8'hf0, 8'h00, "read stop");
    chk({6'h00, u_far.ackLog[0], u_far.ackLog[1]}, 8'h01, "acks");
    // slave receiver: address acked, data byte refused
    acc(1'b1, 4'h8, 8'h54);
    u_far.ackLog.delete();
    fork
      begin
        u_far.mStart(8'h54);
        u_far.mByte(8'h96);
      end
      begin
        waitCtl(8'hfd, 8'h09, "slave addr");
        acc(1'b1, 4'h0, 8'h02);
        waitCtl(8'hfd, 8'h09, "slave byte");
        rdChk(4'h4, 8'hff, 8'h96, "slave data");
        acc(1'b1, 4'h0, 8'h00);
      end
    join
    chk({6'h00, u_far.ackLog[0], u_far.ackLog[1]}, 8'h01, "s acks");
    u_far.mStop();
    // address refused: the next byte stays silent
    u_far.ackLog.delete();
    fork
      begin
        u_far.mStart(8'h54);
        u_far.mByte(8'h33);
      end
      begin
        waitCtl(8'h01, 8'h01, "addr again");
        acc(1'b1, 4'h0, 8'h00);
      end
    join
    rdChk(4'h0, 8'h09, 8'h00, "muted");
    chk({6'h00, u_far.ackLog[0], u_far.ackLog[1]}, 8'h03, "no ack");
    u_far.mStop();
    // slave transmitter, master refuses the byte
    fork
      begin
        u_far.mStart(8'h55);
        u_far.mRead(1'b1);
      end
      begin
        waitCtl(8'hfd, 8'h09, "read addr rx");
        acc(1'b1, 4'h4, 8'h5a);
        acc(1'b1, 4'h0, 8'h02);
        waitCtl(8'hf3, 8'h41, "tx after nack");
        acc(1'b1, 4'h4, 8'h77);
        rdChk(4'h0, 8'h04, 8'h04, "error flag");
        acc(1'b1, 4'h0, 8'h00);
      end
    join
    chk(u_far.rdByte, 8'h5a, "slave sent");
    u_far.mStop();
    waitCtl(8'h40, 8'h00, "left tx");
    test_done();
  end
endmodule : smbus_transfer_mode_control_test
